// [src/acp_cfg.svh]
`ifndef ACP_CFG_SVH
`define ACP_CFG_SVH

// ==========================================================================
// Register byte addresses
`define ACP_ADDR_RES_LOW 8'h20
`define ACP_ADDR_RES_HIGH 8'h21
`define ACP_ADDR_CTRL 8'h22
`define ACP_ADDR_CLK_SEL 8'h23
`define ACP_ADDR_IRQ_STAT 8'h24
`define ACP_ADDR_IRQ_CLR 8'h25
`define ACP_ADDR_IRQ_EN 8'h26

// ==========================================================================
// Field positions
`define ACP_CTRL_START 7
`define ACP_CTRL_BUSY 6
`define ACP_CSEL_TEST 7
`define ACP_CSEL_PCFG_MSB 5
`define ACP_CSEL_CH_MSB 4
`define ACP_CTRL_PCFG 5:3
`define ACP_CTRL_CH 2:0
`define ACP_CSEL_CLK 1:0
`define ACP_IRQ_CONV 0
`define ACP_IEN_GLOBAL 7

// ==========================================================================
// Reset values and divider settings
`define ACP_RST_BYTE 8'h00
`define ACP_CLK_DIV_2 2'h0
`define ACP_CLK_DIV_8 2'h1
`define ACP_CLK_DIV_32 2'h2
`define ACP_DIV_LIM_2 6'h02
`define ACP_DIV_LIM_8 6'h08
`define ACP_DIV_LIM_32 6'h20
`define ACP_PCFG_WIDE 4'h7

`endif

// [src/acp_pkg.sv]
`default_nettype none
package acp_pkg;

  typedef enum logic [2:0]
  {
    ACP_IDLE = 3'b001,
    ACP_ARMED = 3'b010,
    ACP_CONV = 3'b100
  } acp_state_type;

  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } acp_bus_req_type;

endpackage

`default_nettype wire

// [src/acp_core.sv]
// Operation
// - Clock/select bit 4 is the top bit of the 4-bit channel select.
// - Clock/select bit 5 is the top bit of the port configuration code.
// - Clock/select bit 6 is unimplemented and reads zero.
// - Code 0 all digital, 1-6 lowest code pins, 7-15 lowest code+1.
// - Start low-high-low; rise resets converter, following fall starts conversion.
// - Busy flag stays set during conversion; zero means complete.
// - Result appears in high and low result byte registers.
// - Clock/select value 01h selects system clock divided by eight.
// - Control value 20h makes four port B pins analog, input 0.
// - Completion sets interrupt flag; software clears and enables it.
// - Start rising sets busy flag; conversion end clears it.
// - Clock code 00 /2, 01 /8, 10 /32, 11 undefined.
// - High byte holds bits 11-4; low byte upper nibble bits 3-0.
// - Port configuration zero powers the converter down.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "acp_cfg.svh"

module acp_core
#(
  parameter int CONV_PERIODS = 16
)
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire acp_pkg::acp_bus_req_type i_bus,
  output logic [7:0] o_rdata,
  input wire logic [11:0] i_conv_data,
  output logic [3:0] o_channel,
  output logic [15:0] o_analog_en,
  output logic o_adc_power_on,
  output logic o_conv_reset,
  output logic o_irq
);
  import acp_pkg::*;

  // ========================================================================
  // Elaboration check
  generate
    if (CONV_PERIODS < 1 || CONV_PERIODS > 255)
    begin : g_bad_periods
      $error("CONV_PERIODS must lie in 1..255");
    end
  endgenerate

  localparam logic [7:0] PERIOD_LAST = 8'(CONV_PERIODS - 1);

  // ========================================================================
  // Software registers
  logic [2:0] ch_low;
  logic [2:0] pcfg_low;
  logic start;
  logic start_prev;
  logic [1:0] clk_code;
  logic ch_msb;
  logic pcfg_msb;
  logic test_bit;
  logic busy;
  logic [11:0] result;
  logic irq_flag;
  logic irq_en;
  logic global_en;
  acp_state_type state;
  logic [5:0] div_cnt;
  logic [5:0] div_lim;
  logic [7:0] period_cnt;
  logic [11:0] data_meta;
  logic [11:0] data_sync;

  wire logic wr_ctrl = i_bus.wr && (i_bus.addr == `ACP_ADDR_CTRL);
  wire logic wr_csel = i_bus.wr && (i_bus.addr == `ACP_ADDR_CLK_SEL);
  wire logic wr_clr = i_bus.wr && (i_bus.addr == `ACP_ADDR_IRQ_CLR);
  wire logic wr_ien = i_bus.wr && (i_bus.addr == `ACP_ADDR_IRQ_EN);
  wire logic [3:0] pcfg = {pcfg_msb, pcfg_low};
  wire logic start_rise = start && !start_prev;
  wire logic start_fall = !start && start_prev;
  wire logic tick = (state == ACP_CONV) && (div_cnt == div_lim - 6'h01);
  wire logic conv_done = tick && (period_cnt == PERIOD_LAST);

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ch_low <= 3'h0;
      pcfg_low <= 3'h0;
      start <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      ch_low <= i_bus.wdata[`ACP_CTRL_CH];
      pcfg_low <= i_bus.wdata[`ACP_CTRL_PCFG];
      start <= i_bus.wdata[`ACP_CTRL_START];
    end
  end

  // Bit 6 not stored, bit 7 kept but steers nothing
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      clk_code <= 2'h0;
      ch_msb <= 1'b0;
      pcfg_msb <= 1'b0;
      test_bit <= 1'b0;
    end
    else if (wr_csel)
    begin
      clk_code <= i_bus.wdata[`ACP_CSEL_CLK];
      ch_msb <= i_bus.wdata[`ACP_CSEL_CH_MSB];
      pcfg_msb <= i_bus.wdata[`ACP_CSEL_PCFG_MSB];
      test_bit <= i_bus.wdata[`ACP_CSEL_TEST];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      start_prev <= 1'b0;
    end
    else
    begin
      start_prev <= start;
    end
  end

  // ========================================================================
  // Converter data synchroniser
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      data_meta <= 12'h000;
      data_sync <= 12'h000;
    end
    else
    begin
      data_meta <= i_conv_data;
      data_sync <= data_meta;
    end
  end

  // ========================================================================
  // Conversion sequencer
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state <= ACP_IDLE;
    end
    else
    begin
      case (state)
        ACP_IDLE: if (start_rise) state <= ACP_ARMED;
        ACP_ARMED: if (start_fall) state <= ACP_CONV;
        ACP_CONV:
        begin
          if (start_rise)
            state <= ACP_ARMED;
          else if (conv_done)
            state <= ACP_IDLE;
        end
        default: state <= ACP_IDLE;
      endcase
    end
  end

  // Divider limit latched at conversion start
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      div_lim <= `ACP_DIV_LIM_32;
    end
    else if (state == ACP_ARMED && start_fall)
    begin
      case (clk_code)
        `ACP_CLK_DIV_2: div_lim <= `ACP_DIV_LIM_2;
        `ACP_CLK_DIV_8: div_lim <= `ACP_DIV_LIM_8;
        `ACP_CLK_DIV_32: div_lim <= `ACP_DIV_LIM_32;
        default: div_lim <= `ACP_DIV_LIM_32;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      div_cnt <= 6'h00;
      period_cnt <= 8'h00;
    end
    else if (state != ACP_CONV)
    begin
      div_cnt <= 6'h00;
      period_cnt <= 8'h00;
    end
    else if (tick)
    begin
      div_cnt <= 6'h00;
      period_cnt <= period_cnt + 8'h01;
    end
    else
    begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      busy <= 1'b0;
    end
    else if (start_rise)
    begin
      busy <= 1'b1;
    end
    else if (conv_done)
    begin
      busy <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      result <= 12'h000;
    end
    else if (conv_done && !start_rise)
    begin
      result <= data_sync;
    end
  end

  // ========================================================================
  // Interrupt, set wins over clear
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      irq_flag <= 1'b0;
    end
    else if (conv_done && !start_rise)
    begin
      irq_flag <= 1'b1;
    end
    else if (wr_clr && i_bus.wdata[`ACP_IRQ_CONV])
    begin
      irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      irq_en <= 1'b0;
      global_en <= 1'b0;
    end
    else if (wr_ien)
    begin
      irq_en <= i_bus.wdata[`ACP_IRQ_CONV];
      global_en <= i_bus.wdata[`ACP_IEN_GLOBAL];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_irq <= 1'b0;
    end
    else
    begin
      o_irq <= irq_flag && irq_en && global_en;
    end
  end

  // ========================================================================
  // Pin configuration and converter controls
  wire logic [4:0] analog_count = (pcfg >= `ACP_PCFG_WIDE) ? {1'b0, pcfg} + 5'h01
                                                          : {1'b0, pcfg};

  genvar pin;
  generate
    for (pin = 0; pin < 16; pin++)
    begin : g_pin
      always_ff @(posedge i_sys_clk or negedge i_rstn)
      begin
        if (!i_rstn)
          o_analog_en[pin] <= 1'b0;
        else
          o_analog_en[pin] <= (5'(pin) < analog_count);
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_channel <= 4'h0;
      o_adc_power_on <= 1'b0;
      o_conv_reset <= 1'b0;
    end
    else
    begin
      o_channel <= {ch_msb, ch_low};
      o_adc_power_on <= (pcfg != 4'h0);
      o_conv_reset <= (state == ACP_ARMED);
    end
  end

  // ========================================================================
  // Read port
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_rdata <= `ACP_RST_BYTE;
    end
    else if (!i_bus.rd)
    begin
      o_rdata <= `ACP_RST_BYTE;
    end
    else
    begin
      case (i_bus.addr)
        `ACP_ADDR_RES_LOW: o_rdata <= {result[3:0], 4'h0};
        `ACP_ADDR_RES_HIGH: o_rdata <= result[11:4];
        `ACP_ADDR_CTRL: o_rdata <= {start, busy, pcfg_low, ch_low};
        `ACP_ADDR_CLK_SEL: o_rdata <= {test_bit, 1'b0, pcfg_msb, ch_msb, 2'h0, clk_code};
        `ACP_ADDR_IRQ_STAT: o_rdata <= {7'h00, irq_flag};
        `ACP_ADDR_IRQ_EN: o_rdata <= {global_en, 6'h00, irq_en};
        default: o_rdata <= `ACP_RST_BYTE;
      endcase
    end
  end

  // ========================================================================
  // Assertions
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  sequence seq_rise;
    start_rise;
  endsequence

  sequence seq_fall_armed;
    state == ACP_ARMED && start_fall;
  endsequence

  start_sets_busy_a: assert property (seq_rise |=> busy)
    else $error("busy not set after start rise");

  start_pulse_conv_a: assert property (seq_rise ##1 seq_fall_armed |=> state == ACP_CONV && busy)
    else $error("start pulse did not begin conversion");

  done_result_a: assert property (conv_done && !start_rise |=> !busy && result == $past(data_sync))
    else $error("result not captured as busy cleared");

  done_irq_a: assert property (conv_done && !start_rise |=> irq_flag)
    else $error("interrupt flag not set at completion");

  unused_bit_zero_a: assert property (i_bus.rd && i_bus.addr == `ACP_ADDR_CLK_SEL |=> !o_rdata[6])
    else $error("clock select bit 6 read nonzero");

  full_analog_a: assert property (pcfg == 4'hF |=> o_analog_en == 16'hFFFF)
    else $error("code 15 not all analog");

  code_seven_a: assert property (pcfg == `ACP_PCFG_WIDE |=> o_analog_en == 16'h00FF)
    else $error("code 7 not all port B analog");

  power_down_a: assert property (pcfg == 4'h0 |=> !o_adc_power_on && o_analog_en == 16'h0000)
    else $error("converter not powered down");

  channel_msb_a: assert property (##1 o_channel[3] == $past(ch_msb))
    else $error("channel top bit mismatch");

  div_eight_a: assert property (tick && div_lim == `ACP_DIV_LIM_8 |=> (!tick)[*7])
    else $error("divide by eight tick spacing wrong");

  high_byte_a: assert property (i_bus.rd && i_bus.addr == `ACP_ADDR_RES_HIGH |=> o_rdata == $past(result[11:4]))
    else $error("result high byte wrong");

endmodule // acp_core

`default_nettype wire

// [tb/acp_far_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ======================================================================
// Analog pin side: one sample word, tagged by the selected channel
module acp_far_model
(
  input wire logic i_clk,
  input wire logic i_power_on,
  input wire logic [3:0] i_channel,
  input wire logic [11:0] i_sample,
  output logic [11:0] o_conv_data
);
  logic [11:0] noise = 12'h000;

  // Unpowered converter output wanders every cycle
  always @(posedge i_clk)
    noise <= noise + 12'h5A3;

  assign o_conv_data = i_power_on ? (i_sample ^ {i_channel, 8'h00}) : noise;
endmodule // acp_far_model
`default_nettype wire

// [tb/adc_channel_port_control_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "acp_cfg.svh"
module adc_channel_port_control_bench;
  import acp_pkg::*;
  localparam int P = 2;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  acp_bus_req_type bus = '0;
  logic [11:0] sample = 12'h000;
  logic [11:0] conv;
  logic [7:0] rdata;
  logic [3:0] chan;
  logic [15:0] aen;
  logic pwr;
  logic crst;
  logic irq;
  logic rd_pend = 1'b0;
  logic [8:0] note;
  logic [8:0] exp_q [$];
  logic [3:0] ch;
  logic [3:0] cd;
  logic [7:0] ens [4] = '{8'h81, 8'h01, 8'h80, 8'h81};
  int seed = 32'h21a24aff;
  int fail_count = 0;
  int compares = 0;

  always #4 clk = ~clk;

  acp_core #(.CONV_PERIODS(P)) u_dut (.i_sys_clk(clk), .i_rstn(rstn), .i_bus(bus),
    .o_rdata(rdata), .i_conv_data(conv), .o_channel(chan), .o_analog_en(aen),
    .o_adc_power_on(pwr), .o_conv_reset(crst), .o_irq(irq));
  acp_far_model u_far (.i_clk(clk), .i_power_on(pwr), .i_channel(chan),
    .i_sample(sample), .o_conv_data(conv));

  // ======================================================================
  // Shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    bus.rd <= 1'b0;
    @(posedge clk);
  endtask

  // Flag c clear: data is not compared
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic c);
    exp_q.push_back({c, e});
    bus.addr <= a;
    bus.wr <= 1'b0;
    bus.rd <= 1'b1;
    @(posedge clk);
  endtask

  task automatic idle(input int n);
    bus.wr <= 1'b0;
    bus.rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask

  function automatic logic [15:0] pins(input logic [3:0] c);
    int k;
    k = (c == 4'h0) ? 0 : (c < 4'h7) ? int'(c) : int'(c) + 1;
    return 16'((32'h1 << k) - 1);
  endfunction

  task automatic convert(input logic [7:0] c, input logic [7:0] cs, input logic [7:0] en);
    int n;
    int lo;
    logic busy;
    logic [11:0] r;
    logic [11:0] s;
    lo = P * ((cs[1:0] == 2'h0) ? 2 : (cs[1:0] == 2'h1) ? 8 : 32);
    r = 12'($random(seed));
    s = r ^ {cs[4], c[2:0], 8'h00};
    sample <= r;
    wr(`ACP_ADDR_CLK_SEL, cs);
    wr(`ACP_ADDR_CTRL, c);
    wr(`ACP_ADDR_CTRL, c | 8'h80);
    idle(2);
    rd(`ACP_ADDR_CTRL, c | 8'hC0, 1'b1);
    idle(1);
    chk(crst, 1'b1);
    chk(aen, 16'h000F);
    chk(chan, {cs[4], c[2:0]});
    wr(`ACP_ADDR_CTRL, c);
    wr(`ACP_ADDR_IRQ_CLR, 8'h01);
    wr(`ACP_ADDR_IRQ_EN, en);
    n = 0;
    busy = 1'b1;
    while (busy && n < 300)
    begin
      rd(`ACP_ADDR_CTRL, 8'h00, 1'b0);
      n++;
      if (n > 1)
        busy = (rdata[6] !== 1'b0);
    end
    chk(16'(n >= lo && n <= lo + 3), 16'h1);
    rd(`ACP_ADDR_RES_HIGH, s[11:4], 1'b1);
    rd(`ACP_ADDR_RES_LOW, {s[3:0], 4'h0}, 1'b1);
    rd(`ACP_ADDR_IRQ_STAT, 8'h01, 1'b1);
    rd(`ACP_ADDR_IRQ_EN, en, 1'b1);
    idle(2);
    chk(irq, en == 8'h81);
    chk(crst, 1'b0);
    wr(`ACP_ADDR_IRQ_CLR, 8'h01);
    rd(`ACP_ADDR_IRQ_STAT, 8'h00, 1'b1);
    idle(3);
    chk(irq, 1'b0);
  endtask

  // ======================================================================
  // Read data monitor
  always @(posedge clk)
  begin
    if (rd_pend && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      if (note[8])
        chk(rdata, note[7:0]);
    end
    rd_pend <= bus.rd;
  end

  initial
  begin
    #200000;
    fail_count++;
    end_sim;
  end

  // ======================================================================
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(`ACP_ADDR_CLK_SEL, 8'h00, 1'b1);
    rd(`ACP_ADDR_CTRL, 8'h00, 1'b1);
    rd(8'h30, 8'h00, 1'b1);
    wr(`ACP_ADDR_RES_HIGH, 8'hFF);
    wr(`ACP_ADDR_CLK_SEL, 8'h7F);
    rd(`ACP_ADDR_CLK_SEL, 8'h33, 1'b1);
    rd(`ACP_ADDR_RES_HIGH, 8'h00, 1'b1);
    idle(1);
    $display("test registers done");
    for (int k = 0; k < 16; k++)
    begin
      ch = 4'($random(seed));
      cd = 4'(k);
      wr(`ACP_ADDR_CTRL, {2'b00, cd[2:0], ch[2:0]});
      wr(`ACP_ADDR_CLK_SEL, {2'b00, cd[3], ch[3], 4'h1});
      rd(`ACP_ADDR_CLK_SEL, {2'b00, cd[3], ch[3], 4'h1}, 1'b1);
      idle(3);
      chk(aen, pins(cd));
      chk(chan, ch);
      chk(pwr, cd != 4'h0);
      wr(`ACP_ADDR_CTRL, {2'b10, cd[2:0], ch[2:0]});
      wr(`ACP_ADDR_CTRL, {2'b00, cd[2:0], ch[2:0]});
      idle(24);
    end
    $display("test port configuration done");
    for (int k = 0; k < 4; k++)
      convert(8'h20 | 8'(k ^ 1), 8'(((k & 2) << 3) | k), ens[k]);
    $display("test conversions done");
    end_sim;
  end
endmodule // adc_channel_port_control_bench
`default_nettype wire
